// ==== tb/bru_core_properties.sv ====
`timescale 1ns/1ns
module bru_core_properties import bru_pkg::*; (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic busy
);
  logic [15:0] ins_r;
  logic [3:0] bank_r;
  logic [7:0] rd_r;
  logic rot_ok;
  logic [11:0] ea;
  // Shadows of accepted instruction, bank and fetched byte
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ins_r <= 16'h0000;
      bank_r <= 4'h0;
      rd_r <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == BRU_REG_INSTR && !busy) ins_r <= reg_wdata;
      if (reg_wr && reg_addr == BRU_REG_BANK) bank_r <= reg_wdata[3:0];
      rd_r <= mem_rdata;
    end
  end
  // Opcode is a rotate, and the address it should reach
  assign rot_ok = ins_r[15:10] inside {BRU_OPC_RLN, BRU_OPC_RRC, BRU_OPC_RRN};
  assign ea = ins_r[8] ? {bank_r, ins_r[7:0]} : {(ins_r[7:0] < BRU_ACCESS_SPLIT) ?
    BRU_ACCESS_LOW_BANK : BRU_ACCESS_TOP_BANK, ins_r[7:0]};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_phases; busy [*4] ##1 !busy; endsequence
  sequence s_read; mem_rd ##1 !mem_rd; endsequence
  property p_cycle; $rose(busy) |-> s_phases; endproperty
  a_cycle: assert property (p_cycle) else $error("busy length wrong");
  property p_read; $rose(busy) |=> s_read; endproperty
  a_read: assert property (p_read) else $error("read not in Q2");
  property p_wq4; mem_wr |-> $past(mem_rd, 2); endproperty
  a_wq4: assert property (p_wq4) else $error("write not in Q4");
  property p_dest; mem_rd && rot_ok |-> ##2 (mem_wr == ins_r[BRU_DEST_BIT]); endproperty
  a_dest: assert property (p_dest) else $error("dest write wrong");
  property p_addr; mem_rd && rot_ok |-> mem_addr == ea; endproperty
  a_addr: assert property (p_addr) else $error("address wrong");
  property p_hold; mem_rd |=> $stable(mem_addr) [*2]; endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_rln; mem_wr && ins_r[15:10] == BRU_OPC_RLN |-> mem_wdata == {rd_r[6:0], rd_r[7]};
  endproperty
  a_rln: assert property (p_rln) else $error("left rotate wrong");
  property p_rrn; mem_wr && ins_r[15:10] == BRU_OPC_RRN |-> mem_wdata == {rd_r[0], rd_r[7:1]};
  endproperty
  a_rrn: assert property (p_rrn) else $error("right rotate wrong");
endmodule
bind bru_core bru_core_properties bru_core_properties_inst (.clk_sys(clk_sys),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
  .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .busy(busy));

// ==== tb/bru_mem_model.sv ====
`timescale 1ns/1ns
module bru_mem_model (
  input wire logic clk_sys,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:4095];
  initial mem_rdata = 8'h00;
  // Data stands one cycle after the read, then toggles so stale use shows
  always @(posedge clk_sys) begin
    if (mem_rd) mem_rdata <= mem[mem_addr];
    else mem_rdata <= ~mem_rdata;
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb import bru_pkg::*;;
  logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, mem_rd, mem_wr, busy;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [11:0] mem_addr;
  logic [7:0] mem_rdata, mem_wdata;
  logic [5:0] ops [3] = '{BRU_OPC_RLN, BRU_OPC_RRC, BRU_OPC_RRN};
  logic [7:0] cs [4] = '{8'h00, 8'h01, 8'h80, 8'hab};
  int fail_count = 0, n_tests = 0, cyc = 0;
  logic [31:0] r;
  logic [15:0] v0;
  always #25 clk_sys = ~clk_sys;
  bru_core bru_core_inst (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .busy(busy));
  bru_mem_model bru_mem_model_inst (.clk_sys(clk_sys), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      summarize;
    end
  end
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask
  // Carry out then result for each rotate
  function automatic logic [8:0] rot(logic [5:0] o, logic [7:0] s, logic c);
    if (o == BRU_OPC_RLN) return {c, s[6:0], s[7]};
    if (o == BRU_OPC_RRC) return {s[0], c, s[7:1]};
    return {c, s[0], s[7:1]};
  endfunction
  task run(input logic [5:0] o, input logic d, a, input logic [7:0] f, input logic [3:0] b,
           input logic [7:0] s, input logic c);
    logic [8:0] e;
    logic [11:0] ad;
    logic [15:0] v;
    int k;
    e = rot(o, s, c);
    ad = a ? {b, f} : {(f < 8'h80) ? 4'h0 : 4'hf, f};
    bru_mem_model_inst.mem[ad] = s;
    wr(BRU_REG_BANK, {12'h000, b});
    wr(BRU_REG_WORK, {8'h00, ~e[7:0]});
    // Preset N and Z opposite to what the rotate must produce
    wr(BRU_REG_STATUS, {13'h0000, ~e[7], e[7:0] != 8'h00, c});
    wr(BRU_REG_INSTR, {o, d, a, f});
    k = 0;
    @(negedge clk_sys);
    while (busy !== 1'b0 && k < 20) begin
      @(negedge clk_sys);
      k++;
    end
    `CHK(k, BRU_PHASES)
    rd(BRU_REG_WORK, v);
    `CHK(v[7:0], d ? ~e[7:0] : e[7:0])
    rd(BRU_REG_STATUS, v);
    `CHK(v[2:0], {e[7], e[7:0] == 8'h00, e[8]})
    `CHK(bru_mem_model_inst.mem[ad], d ? e[7:0] : s)
    $display("done op %h d %b a %b f %h", o, d, a, f);
  endtask
  initial begin
    r = $urandom(32'h80b5e0b4);
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    // Unsupported opcode: nothing starts, sticky flag set, then cleared
    wr(BRU_REG_INSTR, 16'hfc00);
    @(negedge clk_sys);
    `CHK(busy, 1'b0)
    rd(BRU_REG_STATE, v0);
    `CHK(v0, 16'h0001 << BRU_SS_BADOP)
    wr(BRU_REG_STATE, 16'h0001 << BRU_SS_BADOP);
    rd(BRU_REG_STATE, v0);
    `CHK(v0, 16'h0000)
    // Corners: split boundary of the access bank, zero and edge bytes
    for (int i = 0; i < 3; i++)
      for (int j = 0; j < 4; j++)
        run(ops[i], j[0], j[0] & j[1], 8'h7e + j[7:0], 4'h5, cs[j], j[0] ^ i[0]);
    repeat (40) begin
      r = $urandom;
      run(ops[$urandom_range(2)], r[0], r[1], r[9:2], r[13:10], r[21:14], r[22]);
    end
    summarize;
  end
endmodule

// ==== verilog/bru_bank_addr.sv ====
`timescale 1ns/1ns
module bru_bank_addr import bru_pkg::*; (
  input wire logic bank_sel,
  input wire logic [7:0] faddr,
  input wire logic [3:0] bank_select_register,
  output logic [11:0] addr
);

  // Access bank ignores the bank select register; banked mode uses it
  always_comb begin
    if (bank_sel) begin
      addr = {bank_select_register, faddr};
    end else if (faddr < BRU_ACCESS_SPLIT) begin
      addr = {BRU_ACCESS_LOW_BANK, faddr};
    end else begin
      addr = {BRU_ACCESS_TOP_BANK, faddr};
    end
  end

endmodule

// ==== verilog/bru_core.sv ====
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module bru_core import bru_pkg::*; (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [BRU_ADDR_W-1:0] reg_addr,
  input wire logic [BRU_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [BRU_DATA_W-1:0] reg_rdata,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic busy
);

  bru_phase_t phase_r, phase_nxt;
  bru_instr_t instr_r, instr_nxt;
  logic [11:0] addr_r, addr_nxt;
  logic [7:0] result_r, result_nxt;
  logic carry_res_r, carry_res_nxt;
  logic [7:0] work_r, work_nxt;
  logic [3:0] bank_r, bank_nxt;
  bru_flags_t flags_r, flags_nxt;
  logic badop_r, badop_nxt;
  logic [BRU_DATA_W-1:0] rdata_r, rdata_nxt;
  bru_op_t dec_op;
  logic [11:0] eff_addr;
  logic [7:0] rot_result;
  logic rot_carry;
  logic rot_neg;
  logic rot_zero;
  logic instr_wr;

  // Opcode decode of the word on the register port
  always_comb begin
    unique case (reg_wdata[BRU_OPC_HI:BRU_OPC_LO])
      BRU_OPC_RLN: dec_op = BRU_OP_RLN;
      BRU_OPC_RRC: dec_op = BRU_OP_RRC;
      BRU_OPC_RRN: dec_op = BRU_OP_RRN;
      default: dec_op = BRU_OP_NONE;
    endcase
  end

  assign instr_wr = reg_wr && (reg_addr == BRU_REG_INSTR);

  bru_bank_addr u_bank (
    .bank_sel(instr_r.bank_sel),
    .faddr(instr_r.faddr),
    .bank_select_register(bank_r),
    .addr(eff_addr)
  );

  bru_rotate u_rot (
    .op(instr_r.op),
    .src(mem_rdata),
    .carry_in(flags_r.carry),
    .result(rot_result),
    .carry_out(rot_carry),
    .neg(rot_neg),
    .zero(rot_zero)
  );

  // Phase sequencer and datapath latches
  always_comb begin
    phase_nxt = phase_r;
    instr_nxt = instr_r;
    addr_nxt = addr_r;
    result_nxt = result_r;
    carry_res_nxt = carry_res_r;
    unique case (phase_r)
      BRU_IDLE: begin
        if (instr_wr && dec_op != BRU_OP_NONE) begin
          instr_nxt.op = dec_op;
          instr_nxt.dest = reg_wdata[BRU_DEST_BIT];
          instr_nxt.bank_sel = reg_wdata[BRU_BANK_BIT];
          instr_nxt.faddr = reg_wdata[7:0];
          phase_nxt = BRU_Q1;
        end
      end
      BRU_Q1: begin
        addr_nxt = eff_addr;
        phase_nxt = BRU_Q2;
      end
      BRU_Q2: begin
        phase_nxt = BRU_Q3;
      end
      BRU_Q3: begin
        result_nxt = rot_result;
        carry_res_nxt = rot_carry;
        phase_nxt = BRU_Q4;
      end
      BRU_Q4: begin
        phase_nxt = BRU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_r <= BRU_IDLE;
      instr_r <= '0;
      addr_r <= 12'h000;
      result_r <= 8'h00;
      carry_res_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      instr_r <= instr_nxt;
      addr_r <= addr_nxt;
      result_r <= result_nxt;
      carry_res_r <= carry_res_nxt;
    end
  end

  // Software-visible registers; the Q4 write wins over a same-cycle software write
  always_comb begin
    work_nxt = work_r;
    bank_nxt = bank_r;
    flags_nxt = flags_r;
    badop_nxt = badop_r;
    if (reg_wr && reg_addr == BRU_REG_WORK) begin
      work_nxt = reg_wdata[7:0];
    end
    if (reg_wr && reg_addr == BRU_REG_BANK) begin
      bank_nxt = reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == BRU_REG_STATUS) begin
      flags_nxt.carry = reg_wdata[BRU_ST_CARRY];
      flags_nxt.zero = reg_wdata[BRU_ST_ZERO];
      flags_nxt.neg = reg_wdata[BRU_ST_NEG];
    end
    if (reg_wr && reg_addr == BRU_REG_STATE && reg_wdata[BRU_SS_BADOP]) begin
      badop_nxt = 1'b0;
    end
    // Sticky bad-opcode flag; a new event wins over the clear
    if (instr_wr && dec_op == BRU_OP_NONE && phase_r == BRU_IDLE) begin
      badop_nxt = 1'b1;
    end
    if (phase_r == BRU_Q4) begin
      if (!instr_r.dest) begin
        work_nxt = result_r;
      end
      flags_nxt.neg = result_r[7];
      flags_nxt.zero = (result_r == 8'h00);
      if (instr_r.op == BRU_OP_RRC) begin
        flags_nxt.carry = carry_res_r;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      work_r <= BRU_WORK_RST;
      bank_r <= BRU_BANK_RST;
      flags_r <= '0;
      badop_r <= 1'b0;
    end else begin
      work_r <= work_nxt;
      bank_r <= bank_nxt;
      flags_r <= flags_nxt;
      badop_r <= badop_nxt;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        BRU_REG_WORK: rdata_nxt = {8'h00, work_r};
        BRU_REG_BANK: rdata_nxt = {12'h000, bank_r};
        BRU_REG_STATUS: begin
          rdata_nxt[BRU_ST_CARRY] = flags_r.carry;
          rdata_nxt[BRU_ST_ZERO] = flags_r.zero;
          rdata_nxt[BRU_ST_NEG] = flags_r.neg;
        end
        BRU_REG_STATE: begin
          rdata_nxt[BRU_SS_BUSY] = (phase_r != BRU_IDLE);
          rdata_nxt[BRU_SS_BADOP] = badop_r;
          rdata_nxt[BRU_SS_PHASE +: 3] = phase_r;
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Data memory port and status outputs
  assign reg_rdata = rdata_r;
  assign mem_addr = addr_r;
  assign mem_rd = (phase_r == BRU_Q2);
  assign mem_wr = (phase_r == BRU_Q4) && instr_r.dest;
  assign mem_wdata = result_r;
  assign busy = (phase_r != BRU_IDLE);

endmodule

// ==== verilog/bru_pkg.sv ====
package bru_pkg;

  // Register port geometry
  localparam int BRU_ADDR_W = 4;
  localparam int BRU_DATA_W = 16;

  // Register indices on the register port
  localparam logic [3:0] BRU_REG_INSTR = 4'h0;
  localparam logic [3:0] BRU_REG_WORK = 4'h1;
  localparam logic [3:0] BRU_REG_STATUS = 4'h2;
  localparam logic [3:0] BRU_REG_BANK = 4'h3;
  localparam logic [3:0] BRU_REG_STATE = 4'h4;

  // Status register field positions
  localparam int BRU_ST_CARRY = 0;
  localparam int BRU_ST_ZERO = 1;
  localparam int BRU_ST_NEG = 2;

  // State register field positions
  localparam int BRU_SS_BUSY = 0;
  localparam int BRU_SS_BADOP = 1;
  localparam int BRU_SS_PHASE = 2;

  // Reset values
  localparam logic [7:0] BRU_WORK_RST = 8'h00;
  localparam logic [3:0] BRU_BANK_RST = 4'h0;

  // Opcode upper six bits for each rotate
  localparam logic [5:0] BRU_OPC_RLN = 6'h11;
  localparam logic [5:0] BRU_OPC_RRC = 6'h0c;
  localparam logic [5:0] BRU_OPC_RRN = 6'h10;

  // Opcode field positions
  localparam int BRU_OPC_HI = 15;
  localparam int BRU_OPC_LO = 10;
  localparam int BRU_DEST_BIT = 9;
  localparam int BRU_BANK_BIT = 8;

  // Access bank: low part maps to bank 0, upper part to the top bank
  localparam logic [7:0] BRU_ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] BRU_ACCESS_TOP_BANK = 4'hf;
  localparam logic [3:0] BRU_ACCESS_LOW_BANK = 4'h0;

  // Phases per instruction cycle
  localparam int BRU_PHASES = 4;

  typedef enum logic [1:0] {
    BRU_OP_NONE,
    BRU_OP_RLN,
    BRU_OP_RRC,
    BRU_OP_RRN
  } bru_op_t;

  typedef enum logic [2:0] {
    BRU_IDLE,
    BRU_Q1,
    BRU_Q2,
    BRU_Q3,
    BRU_Q4
  } bru_phase_t;

  typedef struct packed {
    bru_op_t op;
    logic dest;
    logic bank_sel;
    logic [7:0] faddr;
  } bru_instr_t;

  typedef struct packed {
    logic neg;
    logic zero;
    logic carry;
  } bru_flags_t;

endpackage

// ==== verilog/bru_rotate.sv ====
`timescale 1ns/1ns
module bru_rotate import bru_pkg::*; (
  input wire bru_op_t op,
  input wire logic [7:0] src,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic neg,
  output logic zero
);

  // Rotate datapath and result flags
  always_comb begin
    result = src;
    carry_out = carry_in;
    unique case (op)
      BRU_OP_NONE: begin
        result = src;
      end
      BRU_OP_RLN: begin
        result = {src[6:0], src[7]};
      end
      BRU_OP_RRC: begin
        result = {carry_in, src[7:1]};
        carry_out = src[0];
      end
      BRU_OP_RRN: begin
        result = {src[0], src[7:1]};
      end
    endcase
    neg = result[7];
    zero = (result == 8'h00);
  end

endmodule
